// [pkg/sac_pkg.sv]
package sac_pkg;

   // ------------------------------------------------------------
   // Register map and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_CHSEL = 8'h08;
   localparam logic [7:0] ADDR_PAIRCFG = 8'h0c;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h10;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h14;

   localparam logic [7:0] CONFIG_RST = 8'hf8;
   localparam logic [3:0] CHSEL_RST = 4'h0;
   localparam logic [3:0] PAIRCFG_RST = 4'h0;

   // ------------------------------------------------------------
   // Field positions and widths
   // ------------------------------------------------------------
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_TM_BIT = 6;
   localparam int CTRL_DONE_BIT = 5;
   localparam int CTRL_BUSY_BIT = 4;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_LJ_BIT = 0;
   localparam int CFG_DIV_LSB = 3;
   localparam int CFG_GAIN_LSB = 0;
   localparam int CHSEL_TEMP_BIT = 3;
   localparam int RESULT_W = 12;
   localparam int DIV_W = 5;
   localparam int GAIN_W = 3;
   localparam int MODE_W = 2;
   localparam int CHSEL_W = 4;
   localparam int PAIR_W = 4;
   localparam int BYTE_W = 8;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MIN_CONV_PERIOD_NS = 10000;
   localparam int MIN_CONV_CYCLES = (MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RATE_W = $clog2(MIN_CONV_CYCLES);
   localparam int TRACK_SAR_CLOCKS = 3;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SEL_CTRL = 3'h0, SEL_CONFIG = 3'h1, SEL_CHSEL = 3'h2, SEL_PAIRCFG = 3'h3,
      SEL_RES_HIGH = 3'h4, SEL_RES_LOW = 3'h5, SEL_NONE = 3'h7
   } sac_sel_e;

   typedef enum logic [1:0] {
      START_SW = 2'h0, START_TMR3 = 2'h1, START_EXT = 2'h2, START_TMR2 = 2'h3
   } sac_start_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, ST_TRACK = 4'h2, ST_CONV = 4'h4, ST_FINISH = 4'h8
   } sac_state_e;

   typedef enum logic [2:0] {
      GAIN_X0P5 = 3'h0, GAIN_X1 = 3'h1, GAIN_X2 = 3'h2, GAIN_X4 = 3'h3, GAIN_X8 = 3'h4, GAIN_X16 = 3'h5
   } sac_gain_e;

   typedef struct packed {
      logic temp;
      logic diff;
      logic [2:0] pos;
      logic [2:0] neg;
   } sac_mux_s;

   typedef struct packed {
      logic [BYTE_W-1:0] high;
      logic [BYTE_W-1:0] low;
   } sac_result_s;

endpackage

// [rtl/sac_sar_engine.sv]
`timescale 1ns/1ns
module sac_sar_engine #(
   parameter int W = 12
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_start,
   input wire logic i_tick,
   input wire logic i_abort,
   // Analog comparator, high when input is at or above the trial code
   input wire logic i_cmp,
   // Results
   output logic [W-1:0] o_dac,
   output logic o_done,
   output logic [W-1:0] o_result
);

   logic [W-1:0] code;
   logic [W-1:0] mask;
   logic [W-1:0] kept;

   if (W < 2) begin : g_chk
      $error("sac_sar_engine: W must be at least 2");
   end

   // ------------------------------------------------------------
   // Binary search, one bit per conversion clock, MSB first
   // ------------------------------------------------------------
   assign kept = i_cmp ? code : (code & ~mask);
   assign o_dac = code;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         code <= '0;
         mask <= '0;
         o_done <= 1'b0;
         o_result <= '0;
      end else begin
         o_done <= 1'b0;
         if (i_abort) begin
            mask <= '0;
         end else if (i_start) begin
            mask <= {1'b1, {(W-1){1'b0}}};
            code <= {1'b1, {(W-1){1'b0}}};
         end else if (i_tick && mask != '0) begin
            mask <= mask >> 1;
            code <= kept | (mask >> 1);
            if (mask[0]) begin
               o_done <= 1'b1;
               o_result <= kept;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   done_single_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_done |=> !o_done)
      else $error("done pulse longer than one cycle");

endmodule

// [rtl/sac_top.sv]
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Contract
// - Analog parts powered only while enabled
// - Nine channels: eight inputs plus temperature
// - Pairs single-ended or differential, reset single-ended
// - Six gains from three-bit field, unity reset
// - Temperature selection feeds gain amplifier
// - No more than 100 ksps
// - Conversion clock divided from system clock
// - Four selectable start triggers
// - Busy high through whole conversion
// - Busy fall sets done flag, interrupt
// - Result left or right justified
// - Results are twelve bits
// - Track mode 0: track whenever idle
// - Track mode 1: three-clock track first
// - External start: track low, convert rising
// - No tracking in chip standby
// - Start mode code to trigger mapping
// - Gain code mapping
// - Divider field plus one sets period
module sac_top import sac_pkg::*; #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST,
   // AXI4-Lite write address and data
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [ADDR_W-1:0] I_AWADDR,
   input wire logic [2:0] I_AWPROT,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   // AXI4-Lite write response
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   // AXI4-Lite read
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [ADDR_W-1:0] I_ARADDR,
   input wire logic [2:0] I_ARPROT,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   // Start sources and chip state
   input wire logic I_TMR3_OVF,
   input wire logic I_TMR2_OVF,
   input wire logic I_EXT_CONVERT_START,
   input wire logic I_STANDBY,
   input wire logic I_IRQ_ENABLE,
   // Analog front end
   input wire logic I_CMP,
   output logic O_POWER,
   output logic O_TRACK,
   output sac_mux_s O_MUX,
   output sac_gain_e O_GAIN,
   output logic [RESULT_W-1:0] O_DAC,
   // Status
   output logic O_BUSY,
   output logic O_IRQ
);

   if (ADDR_W < 5) begin : g_chk
      $error("sac_top: ADDR_W must cover the register map");
   end

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic sac_sel_e reg_sel(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(ADDR_CTRL)) begin
         return SEL_CTRL;
      end else if (a == ADDR_W'(ADDR_CONFIG)) begin
         return SEL_CONFIG;
      end else if (a == ADDR_W'(ADDR_CHSEL)) begin
         return SEL_CHSEL;
      end else if (a == ADDR_W'(ADDR_PAIRCFG)) begin
         return SEL_PAIRCFG;
      end else if (a == ADDR_W'(ADDR_RESULT_HIGH)) begin
         return SEL_RES_HIGH;
      end else if (a == ADDR_W'(ADDR_RESULT_LOW)) begin
         return SEL_RES_LOW;
      end else begin
         return SEL_NONE;
      end
   endfunction

   function automatic sac_gain_e gain_decode(input logic [GAIN_W-1:0] g);
      if (g[2]) begin
         return g[1] ? GAIN_X0P5 : GAIN_X16;
      end else begin
         case (g[1:0])
            2'h0: return GAIN_X1;
            2'h1: return GAIN_X2;
            2'h2: return GAIN_X4;
            default: return GAIN_X8;
         endcase
      end
   endfunction

   // Differential codes come back offset binary; flipping the MSB gives two's complement
   function automatic sac_result_s fmt_result(input logic [RESULT_W-1:0] r, input logic lj, input logic diff);
      logic [RESULT_W-1:0] v;
      v = diff ? {~r[RESULT_W-1], r[RESULT_W-2:0]} : r;
      if (lj) begin
         return '{high: v[11:4], low: {v[3:0], 4'h0}};
      end else begin
         return '{high: {4'h0, v[11:8]}, low: v[7:0]};
      end
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic en;
   logic tm;
   logic done_flag;
   logic lj;
   sac_start_e mode;
   logic [DIV_W-1:0] div;
   logic [GAIN_W-1:0] gain;
   logic [CHSEL_W-1:0] chsel;
   logic [PAIR_W-1:0] paircfg;
   sac_result_s result;
   sac_state_e state;
   sac_state_e next_state;
   logic [DIV_W-1:0] div_cnt;
   logic [1:0] trk_cnt;
   logic [RATE_W-1:0] rate_cnt;
   logic ext_q;
   logic sar_done;
   logic [RESULT_W-1:0] sar_result;
   sac_mux_s next_mux;
   logic [1:0] pair;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire do_write = aw_held && w_held && !O_BVALID;
   wire sac_sel_e wr_sel = reg_sel(aw_addr);
   wire sac_sel_e rd_sel = reg_sel(I_ARADDR);
   wire wr_lane = do_write && w_strb[0];
   wire wr_ctrl = wr_lane && wr_sel == SEL_CTRL;
   wire wr_config = wr_lane && wr_sel == SEL_CONFIG;
   wire wr_chsel = wr_lane && wr_sel == SEL_CHSEL;
   wire wr_pair = wr_lane && wr_sel == SEL_PAIRCFG;
   wire rd_take = I_ARVALID && O_ARREADY;
   wire busy = state != ST_IDLE;
   wire [BYTE_W-1:0] ctrl_view = {en, tm, done_flag, busy, mode, 1'b0, lj};
   wire [BYTE_W-1:0] rd_byte =
      rd_sel == SEL_CTRL ? ctrl_view :
      rd_sel == SEL_CONFIG ? {div, gain} :
      rd_sel == SEL_CHSEL ? {4'h0, chsel} :
      rd_sel == SEL_PAIRCFG ? {4'h0, paircfg} :
      rd_sel == SEL_RES_HIGH ? result.high :
      rd_sel == SEL_RES_LOW ? result.low : 8'h00;

   assign O_AWREADY = !aw_held;
   assign O_WREADY = !w_held;
   assign O_ARREADY = !O_RVALID;

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         O_BVALID <= 1'b0;
         O_BRESP <= RESP_OKAY;
      end else begin
         if (I_AWVALID && O_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= I_AWADDR;
         end
         if (I_WVALID && O_WREADY) begin
            w_held <= 1'b1;
            w_data <= I_WDATA;
            w_strb <= I_WSTRB;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP <= wr_sel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
         end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RVALID <= 1'b0;
         O_RDATA <= '0;
         O_RRESP <= RESP_OKAY;
      end else if (rd_take) begin
         O_RVALID <= 1'b1;
         O_RDATA <= {24'h0, rd_byte};
         O_RRESP <= rd_sel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
      end else if (I_RREADY) begin
         O_RVALID <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Start triggers
   // ------------------------------------------------------------
   wire sw_start = wr_ctrl && w_data[CTRL_BUSY_BIT] && mode == START_SW;
   wire ext_rise = I_EXT_CONVERT_START && !ext_q;
   wire trigger = mode == START_SW ? sw_start :
      mode == START_TMR3 ? I_TMR3_OVF :
      mode == START_EXT ? ext_rise : I_TMR2_OVF;
   wire sar_tick = busy && div_cnt == div;
   wire track_end = sar_tick && trk_cnt == 2'(TRACK_SAR_CLOCKS - 1);
   wire conv_start = state != ST_CONV && next_state == ST_CONV;
   wire busy_fall = state == ST_FINISH && next_state == ST_IDLE;

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         en <= 1'b0;
         tm <= 1'b0;
         lj <= 1'b0;
         mode <= START_SW;
         done_flag <= 1'b0;
         div <= CONFIG_RST[CFG_DIV_LSB +: DIV_W];
         gain <= CONFIG_RST[CFG_GAIN_LSB +: GAIN_W];
         chsel <= CHSEL_RST;
         paircfg <= PAIRCFG_RST;
         ext_q <= 1'b0;
      end else begin
         ext_q <= I_EXT_CONVERT_START;
         if (wr_ctrl) begin
            en <= w_data[CTRL_EN_BIT];
            tm <= w_data[CTRL_TM_BIT];
            lj <= w_data[CTRL_LJ_BIT];
            mode <= sac_start_e'(w_data[CTRL_MODE_LSB +: MODE_W]);
         end
         // Hardware set wins over a simultaneous software clear
         if (busy_fall) begin
            done_flag <= 1'b1;
         end else if (wr_ctrl) begin
            done_flag <= w_data[CTRL_DONE_BIT];
         end
         if (wr_config) begin
            div <= w_data[CFG_DIV_LSB +: DIV_W];
            gain <= w_data[CFG_GAIN_LSB +: GAIN_W];
         end
         if (wr_chsel) begin
            chsel <= w_data[CHSEL_W-1:0];
         end
         if (wr_pair) begin
            paircfg <= w_data[PAIR_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (en && trigger) begin
               next_state = (tm && mode != START_EXT) ? ST_TRACK : ST_CONV;
            end
         end
         ST_TRACK: begin
            if (track_end) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (sar_done) begin
               next_state = ST_FINISH;
            end
         end
         ST_FINISH: begin
            // Busy stretches until the rate window closes, capping throughput
            if (rate_cnt == '0) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (!en) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state <= ST_IDLE;
         div_cnt <= '0;
         trk_cnt <= '0;
         rate_cnt <= '0;
      end else begin
         state <= next_state;
         div_cnt <= (!busy || sar_tick) ? '0 : div_cnt + 1'b1;
         trk_cnt <= state != ST_TRACK ? 2'h0 : (sar_tick ? trk_cnt + 2'h1 : trk_cnt);
         if (state == ST_IDLE && next_state != ST_IDLE) begin
            rate_cnt <= RATE_W'(MIN_CONV_CYCLES - 1);
         end else if (rate_cnt != '0) begin
            rate_cnt <= rate_cnt - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Successive approximation and result
   // ------------------------------------------------------------
   sac_sar_engine #(
      .W(RESULT_W)
   ) u_engine (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_start(conv_start),
      .i_tick(sar_tick && state == ST_CONV),
      .i_abort(!en),
      .i_cmp(I_CMP),
      .o_dac(O_DAC),
      .o_done(sar_done),
      .o_result(sar_result)
   );

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         result <= '0;
      end else if (state == ST_CONV && sar_done && en) begin
         // Taken as the search ends, so the result is settled at least a cycle before busy falls
         result <= fmt_result(sar_result, lj, O_MUX.diff);
      end
   end

   // ------------------------------------------------------------
   // Analog front end
   // ------------------------------------------------------------
   assign pair = chsel[2:1];
   assign next_mux.temp = chsel[CHSEL_TEMP_BIT];
   assign next_mux.diff = !chsel[CHSEL_TEMP_BIT] && paircfg[pair];
   assign next_mux.pos = next_mux.diff ? {pair, 1'b0} : chsel[2:0];
   assign next_mux.neg = {pair, 1'b1};

   // Tracking is a level; standby wins over every mode
   assign O_TRACK = en && !I_STANDBY &&
      (!tm ? state == ST_IDLE :
       state == ST_TRACK || (mode == START_EXT && state == ST_IDLE && !I_EXT_CONVERT_START));
   assign O_BUSY = busy;
   assign O_IRQ = done_flag && I_IRQ_ENABLE;

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_POWER <= 1'b0;
         O_MUX <= '0;
         O_GAIN <= GAIN_X1;
      end else begin
         O_POWER <= en;
         O_MUX <= next_mux;
         O_GAIN <= gain_decode(gain);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   done_on_fall_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      $fell(busy) && $past(en) |-> done_flag)
      else $error("done flag not set when busy fell");

   result_first_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      $fell(busy) && $past(en) |-> $past(state == ST_FINISH) && $stable(result))
      else $error("busy fell without result update");

   disable_idle_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !en |=> state == ST_IDLE && !O_POWER)
      else $error("disabled converter still active");

   busy_ignore_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      state == ST_CONV && en && !sar_done |=> state == ST_CONV)
      else $error("conversion left early");

   track_len_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      state == ST_TRACK && sar_tick && trk_cnt != 2'(TRACK_SAR_CLOCKS - 1) && en |=> state == ST_TRACK)
      else $error("tracking phase shorter than three clocks");

   idle_track_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      !tm && en && !I_STANDBY && state == ST_IDLE |-> O_TRACK)
      else $error("idle without tracking in continuous mode");

   standby_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_STANDBY |-> !O_TRACK)
      else $error("tracking during standby");

   tick_space_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      sar_tick && div != '0 && $stable(div) |=> !sar_tick)
      else $error("conversion clock faster than divider");

   rate_cap_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      $fell(busy) && $past(en) |-> $past(rate_cnt) == '0)
      else $error("conversion rate above limit");

   temp_sel_a: assert property (@(posedge I_CLK) disable iff (I_RST)
      chsel[CHSEL_TEMP_BIT] |=> O_MUX.temp && !O_MUX.diff)
      else $error("temperature channel not routed");

endmodule

// [verif/sac_far_end.sv]
`timescale 1ns/1ns
// ------------------------------------------------
// Analog side: a fixed input level and a comparator
// ------------------------------------------------
module sac_far_end import sac_pkg::*; (
   // Trial code from the converter
   input wire logic [RESULT_W-1:0] i_dac,
   // Level the bench applies to the selected input
   input wire logic [RESULT_W-1:0] i_level,
   // Comparator answer
   output logic o_cmp
);
   // Ideal comparator, so a correct search lands exactly on the level
   assign o_cmp = (i_level >= i_dac);
endmodule

// [verif/sar_adc_conversion_control_bench.sv]
`timescale 1ns/1ns
module sar_adc_conversion_control_bench import sac_pkg::*;;
   logic I_CLK = 1'b0;
   logic rst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic t3 = 1'b0, t2 = 1'b0, ext = 1'b0, stby = 1'b0, irqen = 1'b1, cmp;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [11:0] lvl = 12'h000;
   logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_POWER, O_TRACK, O_BUSY, O_IRQ;
   logic [1:0] O_BRESP, O_RRESP;
   logic [31:0] O_RDATA;
   logic [11:0] O_DAC;
   sac_mux_s O_MUX;
   sac_gain_e O_GAIN;
   int n_errors = 0, checked = 0, cyc = 0, tcnt = 0;
   sac_top i_sac_top (.I_CLK(I_CLK), .I_RST(rst), .I_AWVALID(awv), .O_AWREADY(O_AWREADY), .I_AWADDR(awa),
      .I_AWPROT(3'h0), .I_WVALID(wv), .O_WREADY(O_WREADY), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(O_BVALID),
      .I_BREADY(brdy), .O_BRESP(O_BRESP), .I_ARVALID(arv), .O_ARREADY(O_ARREADY), .I_ARADDR(ara),
      .I_ARPROT(3'h0), .O_RVALID(O_RVALID), .I_RREADY(rrdy), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
      .I_TMR3_OVF(t3), .I_TMR2_OVF(t2), .I_EXT_CONVERT_START(ext), .I_STANDBY(stby), .I_IRQ_ENABLE(irqen),
      .I_CMP(cmp), .O_POWER(O_POWER), .O_TRACK(O_TRACK), .O_MUX(O_MUX), .O_GAIN(O_GAIN), .O_DAC(O_DAC),
      .O_BUSY(O_BUSY), .O_IRQ(O_IRQ));
   sac_far_end i_sac_far_end (.i_dac(O_DAC), .i_level(lvl), .o_cmp(cmp));
   initial begin
      forever #5 I_CLK = ~I_CLK;
   end
   // Track cycles seen inside a conversion
   always @(negedge I_CLK) begin
      if (O_BUSY === 1'b1 && O_TRACK === 1'b1) begin
         tcnt++;
      end
   end
   // Conversions last about 1000 cycles each; six of them fit well inside the ceiling
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         final_report();
      end
   end
   // ------------------------------------------------
   // Bus tasks and checks
   // ------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic pa, pw, ta, tw, b;
      @(posedge I_CLK);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= {24'h0, d};
      brdy <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      b = 1'b0;
      while (pa || pw) begin
         @(negedge I_CLK);
         ta = pa && O_AWREADY;
         tw = pw && O_WREADY;
         @(posedge I_CLK);
         if (ta) begin
            awv <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            wv <= 1'b0;
            pw = 1'b0;
         end
      end
      while (!b) begin
         @(negedge I_CLK);
         b = O_BVALID;
         r = O_BRESP;
         @(posedge I_CLK);
      end
      brdy <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
      logic t;
      @(posedge I_CLK);
      arv <= 1'b1;
      ara <= a;
      rrdy <= 1'b1;
      t = 1'b0;
      while (!t) begin
         @(negedge I_CLK);
         t = O_ARREADY;
         @(posedge I_CLK);
      end
      arv <= 1'b0;
      t = 1'b0;
      while (!t) begin
         @(negedge I_CLK);
         t = O_RVALID;
         d = O_RDATA[7:0];
         r = O_RRESP;
         @(posedge I_CLK);
      end
      rrdy <= 1'b0;
   endtask
   // Start per mode, poll the flag, read and clear, as software should
   task automatic conv(input logic [1:0] m, input logic lj, input logic tm, input logic [11:0] v);
      logic [7:0] h, l;
      logic [1:0] r;
      lvl <= v;
      tcnt = 0;
      // Configure and clear the flag first: a start write uses the mode and track bit already held
      wr(ADDR_CTRL, {1'b1, tm, 1'b0, 1'b0, m, 1'b0, lj}, r);
      @(negedge I_CLK);
      chk("mode track", !tm || m == 2'h2, O_TRACK);
      if (m == 2'h0) wr(ADDR_CTRL, {1'b1, tm, 1'b0, 1'b1, m, 1'b0, lj}, r);
      @(posedge I_CLK);
      t3 <= (m == 2'h1);
      ext <= (m == 2'h2);
      t2 <= (m == 2'h3);
      @(posedge I_CLK);
      t3 <= 1'b0;
      t2 <= 1'b0;
      @(negedge I_CLK);
      chk("busy", 1, O_BUSY);
      h = 8'h00;
      while (!h[CTRL_DONE_BIT]) rd(ADDR_CTRL, h, r);
      chk("busy end", 0, h[CTRL_BUSY_BIT]);
      chk("irq", irqen, O_IRQ);
      chk("track", tm && m != 2'h2 ? TRACK_SAR_CLOCKS * 32 : 0, tcnt);
      rd(ADDR_RESULT_HIGH, h, r);
      rd(ADDR_RESULT_LOW, l, r);
      chk("result", lj ? {v, 4'h0} : {4'h0, v}, {h, l});
      wr(ADDR_CTRL, 8'h80, r);
      ext <= 1'b0;
      @(negedge I_CLK);
      chk("irq clear", 0, O_IRQ);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      logic [7:0] d;
      logic [1:0] r;
      logic [7:0] rv [4];
      sac_gain_e gx [8];
      rv = '{8'h00, CONFIG_RST, {4'h0, CHSEL_RST}, {4'h0, PAIRCFG_RST}};
      gx = '{GAIN_X1, GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16, GAIN_X16, GAIN_X0P5, GAIN_X0P5};
      repeat (4) @(posedge I_CLK);
      rst <= 1'b0;
      @(negedge I_CLK);
      chk("power off", 0, O_POWER);
      chk("gain reset", GAIN_X1, O_GAIN);
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * i), d, r);
         chk("reset value", rv[i], d);
      end
      rd(8'h18, d, r);
      chk("unmapped read", RESP_SLVERR, r);
      wr(8'h18, 8'hff, r);
      chk("unmapped write", RESP_SLVERR, r);
      for (int g = 0; g < 8; g++) begin
         wr(ADDR_CONFIG, {5'h1f, 3'(g)}, r);
         @(negedge I_CLK);
         chk("gain", gx[g], O_GAIN);
      end
      wr(ADDR_CONFIG, CONFIG_RST, r);
      wr(ADDR_CHSEL, 8'h08, r);
      @(negedge I_CLK);
      chk("temp select", 1, O_MUX.temp);
      wr(ADDR_PAIRCFG, 8'h01, r);
      wr(ADDR_CHSEL, 8'h01, r);
      @(negedge I_CLK);
      chk("pair", 8'h41, O_MUX);
      wr(ADDR_PAIRCFG, 8'h00, r);
      wr(ADDR_CHSEL, 8'h00, r);
      wr(ADDR_CTRL, 8'h80, r);
      @(negedge I_CLK);
      chk("power on", 1, O_POWER);
      chk("idle track", 1, O_TRACK);
      @(posedge I_CLK);
      stby <= 1'b1;
      @(negedge I_CLK);
      chk("standby track", 0, O_TRACK);
      @(posedge I_CLK);
      stby <= 1'b0;
      for (int m = 0; m < 4; m++) conv(2'(m), m[0], 1'b0, 12'ha5c + 12'(m * 257));
      conv(2'h0, 1'b0, 1'b1, 12'h3c7);
      // Low-power tracking on the external start, with the interrupt masked
      @(posedge I_CLK);
      irqen <= 1'b0;
      conv(2'h2, 1'b1, 1'b1, 12'h1e4);
      wr(ADDR_CTRL, 8'h00, r);
      @(negedge I_CLK);
      chk("power down", 0, O_POWER);
      final_report();
   end
endmodule
